// File: rtl/dcsm_top.sv
/*
 * drive control state machine: power-up sequencing, command-driven state
 * changes, fault reaction and fault, state report word and drive levels.
 * assumes one 200 MHz clock; command writes, init_done, fatal_error, fault_event
 * and warning come from logic on mclk; drive_enable_pin is an asynchronous pin.
 */
// Operation
// - after power-up step through start and init to switch-on-disabled unaided
// - command word is write-only; commands are decoded only on its writes
// - present state is always readable in the state report word
// - internal bridge-disabling fault forces fault reaction, then fault
// - a fault-reset command write returns fault state to switch-on-disabled
// - init keeps drive disabled and leaves once initialization completes
// - entering switch-on-disabled with fatal error issues internal fault reset
// - shutdown in switch-on-disabled goes to ready-to-switch-on
// - ready-to-switch-on: no motor energy, loops and function off
// - switch-on in ready-to-switch-on goes to switched-on
// - disable-voltage or quick-stop in ready-to-switch-on goes to switch-on-disabled
// - switched-on: bridge on, loops run, zero command, targets ignored
// - enable-operation in switched-on goes to operation-enabled
// - shutdown in switched-on goes to ready-to-switch-on
// - disable-voltage or quick-stop in switched-on goes to switch-on-disabled
// - operation-enabled powers motor, runs loops, processes targets
// - quick-stop in operation-enabled goes to quick-stop-active
// - shutdown in operation-enabled goes straight to ready-to-switch-on
// - disable-voltage or drive-enable low in operation-enabled goes to switch-on-disabled
// - switch-on in operation-enabled goes back to switched-on
// - quick-stop-active decelerates with stop limit, loops keep holding
// - fault reaction leaves by itself for fault, within 100us to 2ms
// - fault keeps power off until fault reset, then switch-on-disabled
`timescale 1ns/1ps
`default_nettype none

module dcsm_top
#(
	parameter int FREACT_CYCLES = dcsm_pkg::FREACT_MIN_CYCLES
)
(
	// clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// command word write
	input wire logic cmd_wr,
	input wire logic [dcsm_pkg::CMD_W-1:0] cmd_word,
	// drive events
	input wire logic init_done,
	input wire logic fatal_error,
	input wire logic fault_event,
	input wire logic warning,
	input wire logic drive_enable_pin,
	// state report and drive control
	output logic [dcsm_pkg::CMD_W-1:0] state_report_word,
	output dcsm_pkg::dcsm_drive_type drive_ctl,
	output logic fault_reset_req
);

	typedef struct packed {
		logic en_meta;
		logic en_sync;
		dcsm_pkg::dcsm_state_type st;
		dcsm_pkg::dcsm_drive_type drive;
		logic [dcsm_pkg::CMD_W-1:0] report;
		logic freset_req;
	} dcsm_top_state_type;

	logic rst_meta;
	logic rst_n;
	dcsm_top_state_type s;
	dcsm_top_state_type next_s;
	dcsm_pkg::dcsm_cmd_type cmd;
	dcsm_pkg::dcsm_state_type ns;
	logic freact_done;

	assign state_report_word = s.report;
	assign drive_ctl = s.drive;
	assign fault_reset_req = s.freset_req;

	// reset release through two flip-flops
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	dcsm_cmd_decode u_decode
	(
		.mclk(mclk),
		.rst_n(rst_n),
		.cmd_wr(cmd_wr),
		.cmd_word(cmd_word),
		.cmd(cmd)
	);

	dcsm_freact_timer #(.CYCLES(FREACT_CYCLES)) u_freact
	(
		.mclk(mclk),
		.rst_n(rst_n),
		.run(s.st == dcsm_pkg::ST_FREACT),
		.done(freact_done)
	);

	// drive levels for a state
	function automatic dcsm_pkg::dcsm_drive_type drive_of(input dcsm_pkg::dcsm_state_type st);
		dcsm_pkg::dcsm_drive_type d;
		d = '0;
		unique case (st)
			dcsm_pkg::ST_START, dcsm_pkg::ST_INIT, dcsm_pkg::ST_SOD, dcsm_pkg::ST_RTSO,
			dcsm_pkg::ST_FAULT:
				d = '0;
			dcsm_pkg::ST_SWON:
			begin
				d.bridge_on = 1'b1;
				d.loops_run = 1'b1;
				d.zero_cmd = 1'b1;
			end
			dcsm_pkg::ST_OPEN:
			begin
				d.bridge_on = 1'b1;
				d.loops_run = 1'b1;
				d.target_en = 1'b1;
				d.func_en = 1'b1;
			end
			dcsm_pkg::ST_QSTOP:
			begin
				d.bridge_on = 1'b1;
				d.loops_run = 1'b1;
				d.stop_decel = 1'b1;
			end
			dcsm_pkg::ST_FREACT:
			begin
				d.bridge_on = 1'b1;
				d.loops_run = 1'b1;
				d.target_en = 1'b1;
			end
			default:
				d = '0;
		endcase
		return d;
	endfunction : drive_of

	// state report bits for a state
	function automatic logic [dcsm_pkg::CMD_W-1:0] report_of(
		input dcsm_pkg::dcsm_state_type st, input logic volt, input logic warn);
		logic [dcsm_pkg::CMD_W-1:0] r;
		r = '0;
		unique case (st)
			dcsm_pkg::ST_START, dcsm_pkg::ST_INIT:
				r = '0;
			dcsm_pkg::ST_SOD:
				r[dcsm_pkg::SR_SOD_BIT] = 1'b1;
			dcsm_pkg::ST_RTSO:
			begin
				r[dcsm_pkg::SR_QSTOP_BIT] = 1'b1;
				r[dcsm_pkg::SR_READY_BIT] = 1'b1;
			end
			dcsm_pkg::ST_SWON:
			begin
				r[dcsm_pkg::SR_QSTOP_BIT] = 1'b1;
				r[dcsm_pkg::SR_SWON_BIT] = 1'b1;
				r[dcsm_pkg::SR_READY_BIT] = 1'b1;
			end
			dcsm_pkg::ST_OPEN:
			begin
				r[dcsm_pkg::SR_QSTOP_BIT] = 1'b1;
				r[dcsm_pkg::SR_OPEN_BIT] = 1'b1;
				r[dcsm_pkg::SR_SWON_BIT] = 1'b1;
				r[dcsm_pkg::SR_READY_BIT] = 1'b1;
			end
			dcsm_pkg::ST_QSTOP:
			begin
				r[dcsm_pkg::SR_OPEN_BIT] = 1'b1;
				r[dcsm_pkg::SR_SWON_BIT] = 1'b1;
				r[dcsm_pkg::SR_READY_BIT] = 1'b1;
			end
			dcsm_pkg::ST_FREACT:
			begin
				r[dcsm_pkg::SR_FAULT_BIT] = 1'b1;
				r[dcsm_pkg::SR_OPEN_BIT] = 1'b1;
				r[dcsm_pkg::SR_SWON_BIT] = 1'b1;
				r[dcsm_pkg::SR_READY_BIT] = 1'b1;
			end
			dcsm_pkg::ST_FAULT:
				r[dcsm_pkg::SR_FAULT_BIT] = 1'b1;
			default:
				r = '0;
		endcase
		r[dcsm_pkg::SR_VOLT_BIT] = volt;
		r[dcsm_pkg::SR_WARN_BIT] = warn;
		return r;
	endfunction : report_of

	// next state; commands not valid in a state fall through unchanged
	always_comb
	begin
		next_s = s;
		next_s.en_meta = drive_enable_pin;
		next_s.en_sync = s.en_meta;
		next_s.freset_req = 1'b0;
		ns = s.st;
		unique case (s.st)
			dcsm_pkg::ST_START:
				ns = dcsm_pkg::ST_INIT;
			dcsm_pkg::ST_INIT:
				if (init_done)
					ns = dcsm_pkg::ST_SOD;
			dcsm_pkg::ST_SOD:
				if (fault_event)
					ns = dcsm_pkg::ST_FREACT;
				else if (cmd.shutdown)
					ns = dcsm_pkg::ST_RTSO;
			dcsm_pkg::ST_RTSO:
				if (fault_event)
					ns = dcsm_pkg::ST_FREACT;
				else if (cmd.disable_voltage || cmd.quick_stop)
					ns = dcsm_pkg::ST_SOD;
				else if (cmd.switch_on)
					ns = dcsm_pkg::ST_SWON;
			dcsm_pkg::ST_SWON:
				if (fault_event)
					ns = dcsm_pkg::ST_FREACT;
				else if (cmd.disable_voltage || cmd.quick_stop)
					ns = dcsm_pkg::ST_SOD;
				else if (cmd.shutdown)
					ns = dcsm_pkg::ST_RTSO;
				else if (cmd.enable_op)
					ns = dcsm_pkg::ST_OPEN;
			dcsm_pkg::ST_OPEN:
				if (fault_event)
					ns = dcsm_pkg::ST_FREACT;
				else if (cmd.disable_voltage || !s.en_sync)
					ns = dcsm_pkg::ST_SOD;
				else if (cmd.quick_stop)
					ns = dcsm_pkg::ST_QSTOP;
				else if (cmd.shutdown)
					ns = dcsm_pkg::ST_RTSO;
				else if (cmd.switch_on)
					ns = dcsm_pkg::ST_SWON;
			dcsm_pkg::ST_QSTOP:
				if (fault_event)
					ns = dcsm_pkg::ST_FREACT;
				else if (cmd.disable_voltage || !s.en_sync)
					ns = dcsm_pkg::ST_SOD;
				else if (cmd.enable_op)
					ns = dcsm_pkg::ST_OPEN;
			dcsm_pkg::ST_FREACT:
				if (freact_done)
					ns = dcsm_pkg::ST_FAULT;
			dcsm_pkg::ST_FAULT:
				if (cmd.fault_reset)
					ns = dcsm_pkg::ST_SOD;
			// an illegal state code restarts the power-up sequence
			default:
				ns = dcsm_pkg::ST_START;
		endcase
		if (ns == dcsm_pkg::ST_SOD && s.st != dcsm_pkg::ST_SOD && fatal_error)
			next_s.freset_req = 1'b1;
		next_s.st = ns;
		next_s.drive = drive_of(ns);
		next_s.report = report_of(ns, next_s.drive.bridge_on, warning);
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s <= '0;
			s.st <= dcsm_pkg::ST_START;
		end
		else
			s <= next_s;
	end

	// fault reaction dwell counter, read only by checks
	localparam int FREACT_MAX = dcsm_pkg::FREACT_MAX_CYCLES;
	logic [31:0] freact_age;
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			freact_age <= '0;
		else if (s.st == dcsm_pkg::ST_FREACT)
			freact_age <= freact_age + 32'h1;
		else
			freact_age <= '0;
	end

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	chk_start_to_init: assert property (s.st == dcsm_pkg::ST_START |=> s.st == dcsm_pkg::ST_INIT)
		else $error("start state did not move to init");
	chk_init_exit: assert property (s.st == dcsm_pkg::ST_INIT && init_done
		|=> s.st == dcsm_pkg::ST_SOD ##0 s.report[dcsm_pkg::SR_SOD_BIT])
		else $error("init did not settle in switch-on-disabled");
	chk_fault_entry: assert property (fault_event && s.st inside {
		dcsm_pkg::ST_SOD, dcsm_pkg::ST_RTSO, dcsm_pkg::ST_SWON, dcsm_pkg::ST_OPEN, dcsm_pkg::ST_QSTOP}
		|=> s.st == dcsm_pkg::ST_FREACT ##1 s.st == dcsm_pkg::ST_FREACT)
		else $error("fault event did not start fault reaction");
	chk_freact_bound: assert property (s.st == dcsm_pkg::ST_FREACT |-> freact_age < FREACT_MAX)
		else $error("fault reaction too long");
	chk_freact_min: assert property ($past(s.st) == dcsm_pkg::ST_FREACT
		&& s.st == dcsm_pkg::ST_FAULT |-> $past(freact_age) >= FREACT_CYCLES)
		else $error("fault reaction too short");
	chk_fault_reset: assert property (s.st == dcsm_pkg::ST_FAULT && cmd.fault_reset
		|=> s.st == dcsm_pkg::ST_SOD)
		else $error("fault reset not honoured");
	chk_bridge_off: assert property (s.st inside {dcsm_pkg::ST_INIT, dcsm_pkg::ST_SOD,
		dcsm_pkg::ST_RTSO, dcsm_pkg::ST_FAULT} |-> !s.drive.bridge_on && !s.drive.loops_run)
		else $error("bridge on in a disabled state");
	chk_enable_drop: assert property (s.st == dcsm_pkg::ST_OPEN && !s.en_sync && !fault_event
		|=> s.st == dcsm_pkg::ST_SOD)
		else $error("drive enable drop ignored");
	chk_auto_freset: assert property (s.st == dcsm_pkg::ST_FAULT && cmd.fault_reset
		&& fatal_error |=> fault_reset_req ##1 !fault_reset_req)
		else $error("internal fault reset missing");
	chk_open_report: assert property (s.st == dcsm_pkg::ST_OPEN
		|-> s.report[3:0] == 4'h7 && s.drive.target_en && s.report[dcsm_pkg::SR_VOLT_BIT])
		else $error("operation report or drive wrong");

endmodule : dcsm_top

`default_nettype wire

// File: rtl/dcsm_pkg.sv
/*
 * shared definitions for the drive control state machine: states, decoded
 * commands, drive-control outputs, command and report bit positions, timing.
 * assumes a single 200 MHz drive clock.
 */
package dcsm_pkg;

	// control states
	typedef enum logic [3:0] {
		ST_START, ST_INIT, ST_SOD, ST_RTSO, ST_SWON, ST_OPEN, ST_QSTOP, ST_FREACT, ST_FAULT
	} dcsm_state_type;

	// one-cycle decoded commands
	typedef struct packed {
		logic fault_reset;
		logic disable_voltage;
		logic quick_stop;
		logic shutdown;
		logic switch_on;
		logic enable_op;
	} dcsm_cmd_type;

	// drive-control levels
	typedef struct packed {
		logic bridge_on;
		logic loops_run;
		logic target_en;
		logic zero_cmd;
		logic stop_decel;
		logic func_en;
	} dcsm_drive_type;

	localparam int CMD_W = 16;
	localparam int CMD_SWITCH_BIT = 0;
	localparam int CMD_VOLT_BIT = 1;
	localparam int CMD_QSTOP_BIT = 2;
	localparam int CMD_ENOP_BIT = 3;
	localparam int CMD_FRESET_BIT = 7;

	localparam int SR_READY_BIT = 0;
	localparam int SR_SWON_BIT = 1;
	localparam int SR_OPEN_BIT = 2;
	localparam int SR_FAULT_BIT = 3;
	localparam int SR_VOLT_BIT = 4;
	localparam int SR_QSTOP_BIT = 5;
	localparam int SR_SOD_BIT = 6;
	localparam int SR_WARN_BIT = 7;

	localparam int CLK_PERIOD_NS = 5;
	localparam int FREACT_MIN_NS = 100000;
	localparam int FREACT_MAX_NS = 2000000;
	localparam int FREACT_MIN_CYCLES = (FREACT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FREACT_MAX_CYCLES = FREACT_MAX_NS / CLK_PERIOD_NS;

endpackage : dcsm_pkg

// File: rtl/dcsm_cmd_decode.sv
/*
 * command word decoder: turns each write of the command word into at most one
 * registered command pulse. assumes writes arrive on mclk as one-cycle strobes.
 */
`timescale 1ns/1ps
`default_nettype none

module dcsm_cmd_decode
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// command write
	input wire logic cmd_wr,
	input wire logic [dcsm_pkg::CMD_W-1:0] cmd_word,
	// decoded command
	output dcsm_pkg::dcsm_cmd_type cmd
);

	typedef struct packed {
		logic last_freset;
		dcsm_pkg::dcsm_cmd_type cmd;
	} dcsm_dec_type;

	dcsm_dec_type s;
	dcsm_dec_type next_s;

	assign cmd = s.cmd;

	always_comb
	begin
		next_s = s;
		next_s.cmd = '0;
		if (cmd_wr)
		begin
			next_s.last_freset = cmd_word[dcsm_pkg::CMD_FRESET_BIT];
			if (cmd_word[dcsm_pkg::CMD_FRESET_BIT] && !s.last_freset)
				next_s.cmd.fault_reset = 1'b1;
			else if (!cmd_word[dcsm_pkg::CMD_FRESET_BIT])
			begin
				if (!cmd_word[dcsm_pkg::CMD_VOLT_BIT])
					next_s.cmd.disable_voltage = 1'b1;
				else if (!cmd_word[dcsm_pkg::CMD_QSTOP_BIT])
					next_s.cmd.quick_stop = 1'b1;
				else if (!cmd_word[dcsm_pkg::CMD_SWITCH_BIT])
					next_s.cmd.shutdown = 1'b1;
				else if (!cmd_word[dcsm_pkg::CMD_ENOP_BIT])
					next_s.cmd.switch_on = 1'b1;
				else
					next_s.cmd.enable_op = 1'b1;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			s <= '0;
		else
			s <= next_s;
	end

endmodule : dcsm_cmd_decode

`default_nettype wire

// File: rtl/dcsm_freact_timer.sv
/*
 * fault-reaction dwell timer: done rises after run has been high for
 * CYCLES clocks and falls on the first clock after run drops. assumes run comes from mclk logic.
 */
`timescale 1ns/1ps
`default_nettype none

module dcsm_freact_timer
#(
	parameter int CYCLES = dcsm_pkg::FREACT_MIN_CYCLES
)
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// control
	input wire logic run,
	output logic done
);

	localparam int CW = $clog2(CYCLES + 1);

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic done;
	} dcsm_tmr_type;

	dcsm_tmr_type s;
	dcsm_tmr_type next_s;

	assign done = s.done;

	always_comb
	begin
		next_s = s;
		if (!run)
		begin
			next_s.cnt = '0;
			next_s.done = 1'b0;
		end
		else if (s.cnt == CW'(CYCLES - 1))
			next_s.done = 1'b1;
		else
			next_s.cnt = s.cnt + CW'(1);
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			s <= '0;
		else
			s <= next_s;
	end

endmodule : dcsm_freact_timer

`default_nettype wire

// File: testbench/dcsm_master_model.sv
/*
 * network master model: writes command words as one-cycle strobes.
 * assumes the bench calls write_cmd from its main sequence, one write at a time.
 */
`timescale 1ns/1ps
`default_nettype none

module dcsm_master_model
(
	// clock
	input wire logic mclk,
	// command write
	output var logic cmd_wr,
	output var logic [dcsm_pkg::CMD_W-1:0] cmd_word
);

	initial
	begin
		cmd_wr = 1'b0;
		cmd_word = 16'h0000;
	end

	// write-only command word
	// the word is never read back; between writes the bus shows the inverse
	task automatic write_cmd(input logic [dcsm_pkg::CMD_W-1:0] w);
		@(posedge mclk);
		cmd_wr <= 1'b1;
		cmd_word <= w;
		@(posedge mclk);
		cmd_wr <= 1'b0;
		cmd_word <= ~w;
	endtask : write_cmd

endmodule : dcsm_master_model
`default_nettype wire

// File: testbench/dcsm_top_test.sv
/*
 * self-checking bench for the drive control state machine.
 * assumes the master model drives all command writes; fault reaction shortened to 8 clocks.
 */
`timescale 1ns/1ps
`default_nettype none

module dcsm_top_test;

	localparam int FR = 8;
	logic mclk;
	logic nrst;
	logic init_done;
	logic fatal_error;
	logic fault_event;
	logic warning;
	logic drive_enable_pin;
	logic cmd_wr;
	logic [15:0] cmd_word;
	logic [15:0] state_report_word;
	dcsm_pkg::dcsm_drive_type drive_ctl;
	logic fault_reset_req;
	int n_mismatch;
	int num_checks;
	int n_freset;

	dcsm_master_model master
	(
		.mclk(mclk),
		.cmd_wr(cmd_wr),
		.cmd_word(cmd_word)
	);

	dcsm_top #(.FREACT_CYCLES(FR)) DUT
	(
		.mclk(mclk),
		.nrst(nrst),
		.cmd_wr(cmd_wr),
		.cmd_word(cmd_word),
		.init_done(init_done),
		.fatal_error(fatal_error),
		.fault_event(fault_event),
		.warning(warning),
		.drive_enable_pin(drive_enable_pin),
		.state_report_word(state_report_word),
		.drive_ctl(drive_ctl),
		.fault_reset_req(fault_reset_req)
	);

	initial
	begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	always @(posedge mclk)
		if (fault_reset_req === 1'b1)
			n_freset++;

	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic look(input logic [15:0] rep, input logic [5:0] drv);
		chk("state_report_word", rep, state_report_word);
		chk("drive_ctl", {10'h000, drv}, {10'h000, drive_ctl});
	endtask : look

	task automatic step(input logic [15:0] cmd, input logic [15:0] rep, input logic [5:0] drv);
		master.write_cmd(cmd);
		repeat (3) @(posedge mclk);
		#1;
		look(rep, drv);
	endtask : step

	task automatic t_powerup;
		repeat (6) @(posedge mclk);
		#1;
		look(16'h0000, 6'h00);
		@(posedge mclk);
		init_done <= 1'b1;
		repeat (3) @(posedge mclk);
		#1;
		look(16'h0040, 6'h00);
	endtask : t_powerup

	task automatic t_walk;
		step(16'h0006, 16'h0021, 6'h00);
		step(16'h000F, 16'h0021, 6'h00);
		step(16'h0007, 16'h0033, 6'h34);
		step(16'h000F, 16'h0037, 6'h39);
		step(16'h0007, 16'h0033, 6'h34);
		step(16'h0006, 16'h0021, 6'h00);
		step(16'h0000, 16'h0040, 6'h00);
		step(16'h0006, 16'h0021, 6'h00);
		step(16'h0002, 16'h0040, 6'h00);
		step(16'h0006, 16'h0021, 6'h00);
		step(16'h0007, 16'h0033, 6'h34);
		step(16'h0000, 16'h0040, 6'h00);
		step(16'h0006, 16'h0021, 6'h00);
		step(16'h0007, 16'h0033, 6'h34);
		step(16'h0002, 16'h0040, 6'h00);
		step(16'h0006, 16'h0021, 6'h00);
		step(16'h0007, 16'h0033, 6'h34);
		step(16'h000F, 16'h0037, 6'h39);
		step(16'h0006, 16'h0021, 6'h00);
		step(16'h0007, 16'h0033, 6'h34);
		step(16'h000F, 16'h0037, 6'h39);
		step(16'h0002, 16'h0017, 6'h32);
		step(16'h000F, 16'h0037, 6'h39);
		step(16'h0000, 16'h0040, 6'h00);
	endtask : t_walk

	task automatic t_enable_pin;
		step(16'h0006, 16'h0021, 6'h00);
		step(16'h0007, 16'h0033, 6'h34);
		step(16'h000F, 16'h0037, 6'h39);
		@(posedge mclk);
		drive_enable_pin <= 1'b0;
		repeat (4) @(posedge mclk);
		#1;
		look(16'h0040, 6'h00);
		@(posedge mclk);
		drive_enable_pin <= 1'b1;
	endtask : t_enable_pin

	// quick-stop-active left by disable voltage, then by the enable pin
	task automatic t_qstop_exit;
		step(16'h0006, 16'h0021, 6'h00);
		step(16'h0007, 16'h0033, 6'h34);
		step(16'h000F, 16'h0037, 6'h39);
		step(16'h0002, 16'h0017, 6'h32);
		step(16'h0000, 16'h0040, 6'h00);
		step(16'h0006, 16'h0021, 6'h00);
		step(16'h0007, 16'h0033, 6'h34);
		step(16'h000F, 16'h0037, 6'h39);
		step(16'h0002, 16'h0017, 6'h32);
		@(posedge mclk);
		drive_enable_pin <= 1'b0;
		repeat (4) @(posedge mclk);
		#1;
		look(16'h0040, 6'h00);
		@(posedge mclk);
		drive_enable_pin <= 1'b1;
	endtask : t_qstop_exit

	task automatic t_fault;
		step(16'h0006, 16'h0021, 6'h00);
		step(16'h0007, 16'h0033, 6'h34);
		step(16'h000F, 16'h0037, 6'h39);
		@(posedge mclk);
		fault_event <= 1'b1;
		@(posedge mclk);
		fault_event <= 1'b0;
		@(posedge mclk);
		#1;
		look(16'h001F, 6'h38);
		repeat (FR + 3) @(posedge mclk);
		#1;
		look(16'h0008, 6'h00);
		step(16'h0006, 16'h0008, 6'h00);
		@(posedge mclk);
		fatal_error <= 1'b1;
		n_freset = 0;
		step(16'h0080, 16'h0040, 6'h00);
		chk("fault_reset_req pulses", 16'h0001, n_freset[15:0]);
		@(posedge mclk);
		fatal_error <= 1'b0;
	endtask : t_fault

	// warning level shows in the report word and clears with it
	task automatic t_warning;
		@(posedge mclk);
		warning <= 1'b1;
		repeat (2) @(posedge mclk);
		#1;
		look(16'h00C0, 6'h00);
		@(posedge mclk);
		warning <= 1'b0;
		repeat (2) @(posedge mclk);
		#1;
		look(16'h0040, 6'h00);
	endtask : t_warning

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : end_of_test

	initial
	begin
		n_mismatch = 0;
		num_checks = 0;
		n_freset = 0;
		nrst = 1'b0;
		init_done = 1'b0;
		fatal_error = 1'b0;
		fault_event = 1'b0;
		warning = 1'b0;
		drive_enable_pin = 1'b1;
		repeat (4) @(posedge mclk);
		nrst <= 1'b1;
		t_powerup();
		t_walk();
		t_enable_pin();
		t_qstop_exit();
		t_fault();
		t_warning();
		end_of_test();
	end

	// watchdog, well beyond the roughly 250 cycles of the sequence
	initial
	begin
		#20000;
		n_mismatch++;
		end_of_test();
	end

endmodule : dcsm_top_test
`default_nettype wire
